// ==== inc/nvmem_i2c_pkg.sv ====
// Shared constants and types for the two-wire nonvolatile memory slave.
// Assumes a single 250 MHz system clock that oversamples the bus lines.
package nvmem_i2c_pkg;

  // Memory geometry
  localparam int ADDR_W = 14;
  localparam int MEM_DEPTH = 16384;
  localparam int DATA_W = 8;

  // Slave address layout
  localparam logic [3:0] DEV_TYPE = 4'hA;
  localparam int TYPE_LSB = 4;
  localparam int SEL_LSB = 1;
  localparam int SEL_W = 3;
  localparam int RW_BIT = 0;

  // High-speed master code occupies the top five bits
  localparam logic [4:0] HS_CODE = 5'h01;
  localparam int HS_LSB = 3;

  // Identification readout addresses (write pointer, then read)
  localparam logic [7:0] ID_PTR_WR = 8'hF8;
  localparam logic [7:0] ID_RD = 8'hF9;
  localparam logic [1:0] ID_LAST = 2'h2;

  // Bit counter
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] BITS_PER_BYTE = 4'h8;

  // Bus timing: fastest bus clock and the samples that one half period spans
  localparam longint CLK_HZ = 250_000_000;
  localparam longint SCL_MAX_HZ = 3_400_000;
  localparam int HALF_SCL_CYCLES = int'(CLK_HZ / (2 * SCL_MAX_HZ));

  // Slave protocol states
  typedef enum logic [3:0] {
    S_IDLE,
    S_ADDR,
    S_MAH,
    S_MAL,
    S_WDATA,
    S_IDSEL,
    S_ACK,
    S_TX,
    S_MACK
  } state_e;

endpackage

// ==== inc/line_events_if.sv ====
// Carrier for decoded bus-line events between the sampler and the slave core.
// Assumes all events are one clk_i cycle wide and share the sampler's clock.
`timescale 1ns/1ps
interface line_events_if;
  logic scl_rise; // Clock line rose
  logic scl_fall; // Clock line fell
  logic start; // Data fell while clock high
  logic stop; // Data rose while clock high
  logic sda; // Synchronised data level

  modport src (output scl_rise, scl_fall, start, stop, sda);
  modport dst (input scl_rise, scl_fall, start, stop, sda);
endinterface

// ==== rtl/bus_line_sampler.sv ====
// Two-flop synchronisers and edge/condition decode for the clock and data lines.
// Assumes clk_i runs far faster than the bus clock so every level is seen.
`timescale 1ns/1ps
module bus_line_sampler
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus lines
  input wire logic scl_i,
  input wire logic sda_i,
  // Decoded events
  line_events_if.src ev
);
  import nvmem_i2c_pkg::*;

  logic scl_meta; // First stage, read only by the second
  logic sda_meta; // First stage, read only by the second
  logic scl_s; // Synchronised clock line
  logic sda_s; // Synchronised data line
  logic scl_d; // Previous clock sample
  logic sda_d; // Previous data sample

  // Synchronise and keep one sample of history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Idle bus is high
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_s <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_meta <= scl_i;
      sda_meta <= sda_i;
      scl_s <= scl_meta;
      sda_s <= sda_meta;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  // Edges of the clock and the two framing conditions
  assign ev.scl_rise = scl_s & ~scl_d;
  assign ev.scl_fall = ~scl_s & scl_d;
  assign ev.start = scl_s & scl_d & sda_d & ~sda_s;
  assign ev.stop = scl_s & scl_d & ~sda_d & sda_s;
  assign ev.sda = sda_s;

endmodule

// ==== rtl/nvmem_i2c_slave.sv ====
// Two-wire slave front end of a 16384 x 8 nonvolatile memory.
// Assumes pins arrive unsynchronised; the bus master makes all clocking.
//
// Behaviour
// - Answer only when select bits equal straps, except the ID pointer byte F8 and, once armed, the ID read byte F9
// - Floating strap inputs read as low
// - Data line driven low or released only
// - Shift out after falls, sample on rises
// - Write-protect high blocks every write
// - 16384 bytes, all 14 address bits decoded
// - Slave address then two memory address bytes
// - Writes complete within bus timing, no polling
// - Pure slave, never drives the clock
// - Detect start, stop, data bit, acknowledge
// - Works up to 3.4 MHz and legacy rates
// - Read-only identification value over the bus
// - Type 1010, select bits, direction bit
// - Address increments before ack, wraps to zero
// - Protected writes not acked, address held
// - Master code enters high speed, stop exits
`timescale 1ns/1ps
module nvmem_i2c_slave
#(
  parameter logic [23:0] ID_VALUE = 24'h5A3C71 // Arbitrary identification value
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Two-wire bus
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // Straps and protection
  input wire logic [nvmem_i2c_pkg::SEL_W-1:0] select_strap_inputs_i,
  input wire logic write_protect_i,
  // Status
  output logic hs_mode_o
);
  import nvmem_i2c_pkg::*;

  line_events_if ev (); // Decoded line events

  // Line sampler; only inputs are taken from the clock line
  bus_line_sampler u_sampler
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .ev (ev)
  );

  logic [SEL_W-1:0] strap_meta; // First stage, read only by the second
  logic [SEL_W-1:0] strap; // Synchronised straps
  logic wp_meta; // First stage, read only by the second
  logic wp; // Synchronised write protect

  state_e state; // Protocol state
  state_e ack_next; // State after the ack bit
  logic [CNT_W-1:0] bitcnt; // Bits seen in the current byte
  logic [DATA_W-1:0] shreg; // Receive shift register
  logic [DATA_W-1:0] tx; // Transmit shift register
  logic [ADDR_W-1:0] addr; // Address latch
  logic m_ack; // Master acked the last sent byte
  logic id_mode; // Reads come from the identification value
  logic id_armed; // Identification pointer accepted
  logic [1:0] id_idx; // Identification byte index
  logic [DATA_W-1:0] mem [MEM_DEPTH]; // Storage array

  logic rx_state; // State that receives a byte
  logic rx_done; // Eighth received bit just ended
  logic tx_done; // Eighth sent bit just ended
  logic give_ack; // Acknowledge the received byte
  state_e after; // Where to go once the ack ends
  logic wr_ok; // Data byte may be stored
  logic load_tx; // Start sending a fresh byte
  logic [DATA_W-1:0] rd_byte; // Byte that a read returns

  // Device address compare, shared by normal and identification selection
  function automatic logic addr_match(input logic [DATA_W-1:0] b, input logic [SEL_W-1:0] s);
    addr_match = (b[DATA_W-1:TYPE_LSB] == DEV_TYPE) && (b[TYPE_LSB-1:SEL_LSB] == s);
  endfunction

  // Straps and protect are pins: two flops before use; pull-downs make open pins low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_meta <= '0;
      strap <= '0;
      wp_meta <= 1'b0;
      wp <= 1'b0;
    end
    else
    begin
      strap_meta <= select_strap_inputs_i;
      strap <= strap_meta;
      wp_meta <= write_protect_i;
      wp <= wp_meta;
    end
  end

  // Receive window and byte boundaries
  assign rx_state = (state == S_ADDR) || (state == S_MAH) || (state == S_MAL) ||
                    (state == S_WDATA) || (state == S_IDSEL);
  assign rx_done = ev.scl_fall && rx_state && (bitcnt == BITS_PER_BYTE);
  assign tx_done = ev.scl_fall && (state == S_TX) && (bitcnt == BITS_PER_BYTE);
  assign wr_ok = ~wp;
  assign load_tx = ev.scl_fall && (((state == S_ACK) && (ack_next == S_TX)) ||
                                   ((state == S_MACK) && m_ack));

  // Read source: identification bytes or the array at the latch
  always_comb
  begin
    rd_byte = mem[addr];
    if (id_mode)
    begin
      unique case (id_idx)
        2'h0: rd_byte = ID_VALUE[23:16];
        2'h1: rd_byte = ID_VALUE[15:8];
        default: rd_byte = ID_VALUE[7:0];
      endcase
    end
  end

  // Decide the acknowledge and the follow-on state for a finished byte
  always_comb
  begin
    give_ack = 1'b0;
    after = S_IDLE;
    unique case (state)
      S_ADDR:
      begin
        if (addr_match(shreg, strap))
        begin
          // Direction bit picks read or memory address phase
          give_ack = 1'b1;
          after = shreg[RW_BIT] ? S_TX : S_MAH;
        end
        else if (shreg == ID_PTR_WR)
        begin
          give_ack = 1'b1;
          after = S_IDSEL;
        end
        else if ((shreg == ID_RD) && id_armed)
        begin
          give_ack = 1'b1;
          after = S_TX;
        end
        // Anything else, the master code included, is not acked
      end
      S_MAH:
      begin
        give_ack = 1'b1;
        after = S_MAL;
      end
      S_MAL:
      begin
        give_ack = 1'b1;
        after = S_WDATA;
      end
      S_WDATA:
      begin
        // Protected data gets no ack
        give_ack = wr_ok;
        after = S_WDATA;
      end
      S_IDSEL:
      begin
        give_ack = addr_match(shreg, strap);
        after = S_IDLE;
      end
      default:
      begin
        give_ack = 1'b0;
        after = S_IDLE;
      end
    endcase
  end

  // Protocol sequencing; start and stop override any byte in flight
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= S_IDLE;
      ack_next <= S_IDLE;
    end
    else if (ev.stop)
    begin
      state <= S_IDLE;
    end
    else if (ev.start)
    begin
      state <= S_ADDR;
    end
    else if (rx_done)
    begin
      // No ack leaves the slave deaf until the next start
      state <= give_ack ? S_ACK : S_IDLE;
      ack_next <= after;
    end
    else if (ev.scl_fall && (state == S_ACK))
    begin
      state <= ack_next;
    end
    else if (tx_done)
    begin
      state <= S_MACK;
    end
    else if (ev.scl_fall && (state == S_MACK))
    begin
      // Master no-ack ends the read
      state <= m_ack ? S_TX : S_IDLE;
    end
  end

  // Bit counter: counts rises, clears at each byte boundary
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bitcnt <= '0;
    end
    else if (ev.start || ev.stop)
    begin
      bitcnt <= '0;
    end
    else if (ev.scl_fall && (bitcnt == BITS_PER_BYTE))
    begin
      bitcnt <= '0;
    end
    else if (ev.scl_rise && (rx_state || (state == S_TX)))
    begin
      bitcnt <= bitcnt + 1'b1;
    end
  end

  // Incoming bits are taken on rising clock edges, MSB first
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      shreg <= '0;
    end
    else if (ev.scl_rise && rx_state)
    begin
      shreg <= {shreg[DATA_W-2:0], ev.sda};
    end
  end

  // Master acknowledge is sampled on the rise of the ninth clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      m_ack <= 1'b0;
    end
    else if (ev.scl_rise && (state == S_MACK))
    begin
      m_ack <= ~ev.sda;
    end
    else if (ev.start || ev.stop)
    begin
      m_ack <= 1'b0;
    end
  end

  // Address latch: loaded by the two address bytes, bumped before each data byte's ack
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr <= '0;
    end
    else if (rx_done && (state == S_MAH))
    begin
      // Upper two bits of the high byte are don't-care
      addr[ADDR_W-1:DATA_W] <= shreg[ADDR_W-DATA_W-1:0];
    end
    else if (rx_done && (state == S_MAL))
    begin
      addr[DATA_W-1:0] <= shreg;
    end
    else if (rx_done && (state == S_WDATA) && wr_ok)
    begin
      // Natural 14-bit overflow gives the wrap to zero
      addr <= addr + 1'b1;
    end
    else if (tx_done && !id_mode)
    begin
      addr <= addr + 1'b1;
    end
  end

  // Array write lands on the eighth bit, well inside the ack clock
  always_ff @(posedge clk_i)
  begin
    if (rx_done && (state == S_WDATA) && wr_ok)
    begin
      mem[addr] <= shreg;
    end
  end

  // Identification readout: pointer write arms, read address selects
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      id_mode <= 1'b0;
      id_armed <= 1'b0;
      id_idx <= '0;
    end
    else if (rx_done && (state == S_IDSEL) && give_ack)
    begin
      id_armed <= 1'b1;
    end
    else if (rx_done && (state == S_ADDR) && give_ack)
    begin
      // The armed flag is spent by the read or dropped by normal access
      id_mode <= (shreg == ID_RD);
      id_armed <= 1'b0;
      id_idx <= '0;
    end
    else if (tx_done && id_mode)
    begin
      id_idx <= (id_idx == ID_LAST) ? 2'h0 : id_idx + 2'h1;
    end
  end

  // High-speed flag: set by the master code, cleared only by stop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      hs_mode_o <= 1'b0;
    end
    else if (ev.stop)
    begin
      hs_mode_o <= 1'b0;
    end
    else if (rx_done && (state == S_ADDR) && (shreg[DATA_W-1:HS_LSB] == HS_CODE))
    begin
      // Oversampling already covers 3.4 MHz; the flag only reports the mode
      hs_mode_o <= 1'b1;
    end
  end

  // Transmit shifter: next bit is presented right after each falling edge
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tx <= '0;
    end
    else if (load_tx)
    begin
      tx <= {rd_byte[DATA_W-2:0], 1'b0};
    end
    else if (ev.scl_fall && (state == S_TX) && (bitcnt != BITS_PER_BYTE))
    begin
      tx <= {tx[DATA_W-2:0], 1'b0};
    end
  end

  // Open-drain drive: output level is fixed low, only the enable moves
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end
    else
    begin
      sda_o <= 1'b0;
      if (ev.start || ev.stop)
      begin
        sda_oe_o <= 1'b0;
      end
      else if (rx_done)
      begin
        sda_oe_o <= give_ack;
      end
      else if (load_tx)
      begin
        // A one bit is sent by releasing, never by driving high
        sda_oe_o <= ~rd_byte[DATA_W-1];
      end
      else if (tx_done)
      begin
        sda_oe_o <= 1'b0;
      end
      else if (ev.scl_fall && (state == S_TX))
      begin
        sda_oe_o <= ~tx[DATA_W-1];
      end
      else if (ev.scl_fall && ((state == S_ACK) || (state == S_MACK)))
      begin
        sda_oe_o <= 1'b0;
      end
    end
  end

endmodule

// ==== dv/nvmem_i2c_chk.sv ====
// Port-level checker for the two-wire memory slave.
// Assumes the bus master keeps SCL low >= 8 and high >= 8 clk_i cycles.
`timescale 1ns/1ps
module nvmem_i2c_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus and status
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic hs_mode_o
);
  // Whole block runs on one clock
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_low_only;
    sda_oe_o |-> sda_o == 1'b0;
  endproperty
  a_low_only: assert property (p_low_only) else $error("data line driven high");

  // Drive starts only a few cycles after a clock fall
  property p_oe_rise;
    $rose(sda_oe_o) |-> !scl_i && !$past(scl_i, 1) && ($past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6));
  endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("drive began away from clock fall");

  property p_oe_fall;
    $fell(sda_oe_o) |-> !scl_i && !$past(scl_i, 1) && ($past(scl_i, 4) || $past(scl_i, 5) || $past(scl_i, 6));
  endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("release away from clock fall");

  // Data must not move while the clock is high
  property p_steady;
    scl_i && $past(scl_i, 4) |-> $stable(sda_oe_o);
  endproperty
  a_steady: assert property (p_steady) else $error("data moved with clock high");

  property p_ack_hold;
    $rose(sda_oe_o) |-> sda_oe_o [*8];
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("low bit too short");

  // Fast mode entered only at a byte decision
  property p_hs_set;
    $rose(hs_mode_o) |-> !scl_i && !$past(scl_i, 2);
  endproperty
  a_hs_set: assert property (p_hs_set) else $error("fast mode set with clock high");

  property p_hs_clear;
    scl_i && $rose(sda_i) |-> ##[1:8] !hs_mode_o;
  endproperty
  a_hs_clear: assert property (p_hs_clear) else $error("fast mode kept after stop");

  property p_hs_fall;
    $fell(hs_mode_o) |-> scl_i && sda_i && $past(scl_i, 8);
  endproperty
  a_hs_fall: assert property (p_hs_fall) else $error("fast mode left without stop");

  // Main scenarios reached
  c_ack: cover property ($rose(sda_oe_o));
  c_hs: cover property ($rose(hs_mode_o));
  c_stop: cover property (scl_i && $rose(sda_i));
endmodule

bind nvmem_i2c_slave nvmem_i2c_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hs_mode_o(hs_mode_o));

// ==== dv/i2c_master_model.sv ====
// Behavioural two-wire bus master with an 80 ns clock (20 clk_i cycles).
// Assumes an open-drain data wire resolved by the bench.
`timescale 1ns/1ps
module i2c_master_model
(
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o, // Master owns the clock
  output logic pull_o // High pulls the data wire low
);
  initial
  begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end

  // Step just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // Data changes only while the clock is low
  task automatic bit_out(input logic b);
    tick(2);
    pull_o = !b;
    tick(8);
    scl_o = 1'b1;
    tick(10);
    scl_o = 1'b0;
  endtask

  // Released wire, sampled mid high phase
  task automatic bit_in(output logic b);
    pull_o = 1'b0;
    tick(10);
    scl_o = 1'b1;
    tick(5);
    b = sda_i;
    tick(5);
    scl_o = 1'b0;
  endtask

  // Start or repeated start
  // A full low phase first: a slave ack still driven after the ninth fall
  // must be released before the clock rises, or the release looks like a stop
  task automatic start();
    pull_o = 1'b0;
    tick(10);
    scl_o = 1'b1;
    tick(10);
    pull_o = 1'b1;
    tick(10);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    tick(2);
    pull_o = 1'b1;
    tick(8);
    scl_o = 1'b1;
    tick(10);
    pull_o = 1'b0;
    tick(10);
  endtask

  // Byte out MSB first, returns acknowledge
  task automatic wr(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
      bit_out(d[i]);
    bit_in(b);
    ack = !b;
  endtask

  // Byte in, then acknowledge or not
  task automatic rd(input logic ack, output logic [7:0] d);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_in(b);
      d[i] = b;
    end
    bit_out(!ack);
  endtask
endmodule

// ==== dv/tb.sv ====
// Self-checking bench for the two-wire memory slave.
// Assumes the master model above; the data wire has a pull-up.
`timescale 1ns/1ps
module tb;
  import nvmem_i2c_pkg::*;
  localparam logic [23:0] ID_EXP = 24'h3C96E1; // Arbitrary identification value
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wp = 1'b0;
  logic [2:0] straps = 3'h5;
  logic scl, pull, sda, sda_o, sda_oe_o, hs;
  int errors = 0;
  int n_compared = 0;

  // Wired-AND data line with pull-up
  assign sda = (pull || (sda_oe_o && !sda_o)) ? 1'b0 : 1'b1;

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  i2c_master_model m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));

  nvmem_i2c_slave #(.ID_VALUE(ID_EXP)) DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .select_strap_inputs_i(straps), .write_protect_i(wp),
    .hs_mode_o(hs));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({7'h0, got}, {7'h0, exp});
  endtask

  // Slave address and two address bytes
  task automatic set_addr(input logic [13:0] a);
    logic k;
    m.start();
    m.wr({DEV_TYPE, straps, 1'b0}, k);
    chk_bit(k, 1'b1);
    m.wr({2'h0, a[13:8]}, k);
    chk_bit(k, 1'b1);
    m.wr(a[7:0], k);
    chk_bit(k, 1'b1);
  endtask

  // One byte at the current address
  task automatic rd_cur(input logic [7:0] exp);
    logic k;
    logic [7:0] d;
    m.start();
    m.wr({DEV_TYPE, straps, 1'b1}, k);
    chk_bit(k, 1'b1);
    m.rd(1'b0, d);
    chk(d, exp);
    m.stop();
  endtask

  task automatic sc_select();
    logic k;
    for (int s = 0; s < 8; s++)
    begin
      m.start();
      m.wr({DEV_TYPE, 3'(s), 1'b0}, k);
      chk_bit(k, 1'(s == 5));
      m.stop();
    end
    m.start();
    m.wr({4'hB, straps, 1'b0}, k);
    chk_bit(k, 1'b0);
    m.stop();
    straps = 3'h0; // Open straps read low
    m.tick(4);
    m.start();
    m.wr({DEV_TYPE, 3'h0, 1'b0}, k);
    chk_bit(k, 1'b1);
    m.stop();
  endtask

  // Write across the top of memory, read back through the wrap
  task automatic sc_wrap();
    logic k;
    logic [7:0] d;
    set_addr(14'h3FFE);
    for (int i = 0; i < 4; i++)
    begin
      m.wr(8'hA5 - 8'(i * 8'h33), k);
      chk_bit(k, 1'b1);
    end
    m.stop();
    set_addr(14'h3FFE);
    m.start();
    m.wr({DEV_TYPE, straps, 1'b1}, k);
    chk_bit(k, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      m.rd(1'(i < 2), d);
      chk(d, 8'hA5 - 8'(i * 8'h33));
    end
    m.stop();
    rd_cur(8'hA5 - 8'h99);
  endtask

  // Protected write is refused and leaves data and address alone
  task automatic sc_protect();
    logic k;
    set_addr(14'h0010);
    m.wr(8'h11, k);
    chk_bit(k, 1'b1);
    m.stop();
    wp = 1'b1;
    set_addr(14'h0010);
    m.wr(8'h22, k);
    chk_bit(k, 1'b0);
    m.stop();
    wp = 1'b0;
    m.tick(4);
    rd_cur(8'h11);
  endtask

  // Every master code enters fast mode, stop leaves it
  task automatic sc_hs();
    logic k;
    for (int c = 0; c < 8; c++)
    begin
      m.start();
      m.wr({HS_CODE, 3'(c)}, k);
      chk_bit(k, 1'b0);
      m.tick(6);
      chk_bit(hs, 1'b1);
      m.stop();
      chk_bit(hs, 1'b0);
    end
  endtask

  task automatic sc_id();
    logic k;
    logic [7:0] d;
    m.start();
    m.wr(ID_PTR_WR, k);
    chk_bit(k, 1'b1);
    m.wr({DEV_TYPE, straps, 1'b0}, k);
    chk_bit(k, 1'b1);
    m.start();
    m.wr(ID_RD, k);
    chk_bit(k, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      m.rd(1'(i < 2), d);
      chk(d, ID_EXP[23 - 8 * i -: 8]);
    end
    m.stop();
  endtask

  task automatic complete_run();
    $display("compared=%0d errors=%0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Hang guard: the scenarios need roughly 10600 cycles, so allow almost four times that
  initial
  begin
    repeat (40000) @(posedge clk_i);
    errors++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    m.tick(6);
    sc_select();
    sc_wrap();
    sc_protect();
    sc_hs();
    sc_id();
    complete_run();
  end
endmodule
